// ---- logic/regfile_pkg.sv ----
package regfile_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int NIB_W = 4;
  localparam int PAGE_W = 2;
  localparam int PC_W = 14;
  localparam int SP_W = 10;
  localparam int SP_LOW_W = 6;
  localparam int ENTRY_W = PC_W + 2;
  localparam int LEVELS = 16;
  localparam int NIRQ = 5;
  localparam int CTL_W = 15;
  localparam int PSS_W = 11;
  localparam int CNT_W = 8;
  localparam int OCT_W = 3;
  localparam int PMA_W = 3;
  localparam int MISC_W = 2;
  localparam int ADDR_W = 8;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_ACC = 8'h00;
  localparam logic [7:0] OFS_OPND = 8'h04;
  localparam logic [7:0] OFS_PAGE = 8'h08;
  localparam logic [7:0] OFS_IDX_HI = 8'h0c;
  localparam logic [7:0] OFS_IDX_LO = 8'h10;
  localparam logic [7:0] OFS_SPARE_HI = 8'h14;
  localparam logic [7:0] OFS_SPARE_LO = 8'h18;
  localparam logic [7:0] OFS_FLAGS = 8'h1c;
  localparam logic [7:0] OFS_PC = 8'h20;
  localparam logic [7:0] OFS_SP = 8'h24;
  localparam logic [7:0] OFS_CTL = 8'h28;
  localparam logic [7:0] OFS_PORT = 8'h2c;
  localparam logic [7:0] OFS_MODE = 8'h30;
  localparam logic [7:0] OFS_COUNT = 8'h34;
  localparam logic [7:0] OFS_PSS = 8'h38;

  // ----------------------------------------------------------------
  // Control bit space, reachable by bit clear and test, and by bit set except the request flags
  // ----------------------------------------------------------------
  localparam int BIT_IE = 0;
  localparam int BIT_IF0 = 1;
  localparam int BIT_IM0 = 6;
  localparam int BIT_WATCHDOG_ON_BIT = 11;
  localparam int BIT_CONV = 12;
  localparam int BIT_CUROFF = 13;
  localparam int BIT_REINIT = 14;
  localparam logic [14:0] CTL_RESET = 15'h07c0;
  localparam logic [14:0] CTL_IF_MASK = 15'h003e;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] SP_LOW_RESET = 6'h3f;
  localparam logic [3:0] SP_HIGH = 4'hf;
  localparam logic [5:0] SP_STEP = 6'h04;
  localparam logic [13:0] PC_RESET = 14'h0000;
  localparam logic [3:0] PORT_DATA_RESET = 4'hf;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_LOAD = 4'h1, OP_ARITH = 4'h2, OP_STATUS = 4'h3,
    OP_SET_C = 4'h4, OP_CLR_C = 4'h5, OP_ROTATE_LEFT_INSTR = 4'h6, OP_ROTATE_RIGHT_INSTR = 4'h7,
    OP_BRANCH = 4'h8, OP_CALL = 4'h9, OP_RTN = 4'ha, OP_INTERRUPT_RETURN_INSTR = 4'hb,
    OP_INT = 4'hc, OP_BIT_SET = 4'hd, OP_BIT_CLR = 4'he,
    OP_BIT_TEST = 4'hf
  } op_type;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00, SEQ_PUSH = 2'b01, SEQ_VECT = 2'b10
  } seq_type;

endpackage

// ---- logic/cpu_regfile.sv ----
// Local design decisions: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
// Contract
// - Accumulator and operand register, four bits each
// - Page index plus two nibble indexes address RAM
// - Low index selects discrete port bit
// - Two spare nibbles partner the index registers
// - Carry takes overflow, set, clear, rotate
// - Carry stacked on interrupt, INTERRUPT_RETURN_INSTR restores, SUBROUTINE_RETURN_INSTR not
// - Status takes results, conditions branches and calls
// - Status holds until next updating instruction
// - Status forced to one after branch or call
// - Status stacked on interrupt, restored on return
// - Program counter is fourteen bit counter
// - Stack pointer ten bits, next free slot
// - Push subtracts four, pull adds four
// - Top four pointer bits fixed at ones
// - Reset or reinit bit clear loads 3FF
// - Reset: counter zero, status one, stack empty
// - Reset clears enable and requests, sets masks
// - Reset sets port data, clears directions
// - Reset clears peripheral modes and counters
// - Bit instructions reach control bits; request flag bits by clear and test only
// - Interrupt entry pushes in second cycle, vectors in third
module cpu_regfile
  import regfile_pkg::*;
#(
  parameter int STACK_LEVELS = 16
)
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  // Avalon-MM slave
  input wire logic [regfile_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Core operation port
  input wire logic op_valid_in,
  input wire regfile_pkg::op_type op_code_in,
  input wire logic [2:0] op_sel_in,
  input wire logic [regfile_pkg::NIB_W-1:0] op_data_in,
  input wire logic op_carry_in,
  input wire logic op_flag_in,
  input wire logic [regfile_pkg::PC_W-1:0] op_target_in,
  input wire logic [3:0] op_bit_in,
  output logic op_ready_out,
  // Interrupt request events
  input wire logic [regfile_pkg::NIRQ-1:0] irq_set_in,
  // Register views
  output logic [regfile_pkg::NIB_W-1:0] accumulator_out,
  output logic [regfile_pkg::NIB_W-1:0] operand_out,
  output logic [9:0] ram_addr_out,
  output logic [regfile_pkg::NIB_W-1:0] port_bit_sel_out,
  output logic carry_flag_out,
  output logic branch_condition_flag_out,
  output logic [regfile_pkg::PC_W-1:0] program_counter_out,
  output logic [regfile_pkg::SP_W-1:0] stack_pointer_out,
  output logic [regfile_pkg::CTL_W-1:0] ctl_bits_out,
  output logic [3:0] port_output_data_out,
  output logic [3:0] port_direction_0_out,
  output logic [3:0] discrete_port_direction_0_out
);
  import regfile_pkg::*;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] accumulator, operand_register;
    logic [1:0] ram_page_index;
    logic [3:0] ram_index_high, ram_index_low;
    logic [3:0] spare_index_high, spare_index_low;
    logic carry_flag, status;
    logic [PC_W-1:0] pc;
    logic [SP_LOW_W-1:0] sp_low;
    logic [LEVELS-1:0][ENTRY_W-1:0] stack;
    logic [CTL_W-1:0] ctl;
    seq_type seq;
    logic ready;
    logic [PC_W-1:0] vector;
    logic [3:0] port_data, port_dir, disc_dir;
    logic [PMA_W-1:0] port_mode_a;
    logic [3:0] timer_b_mode_1, serial_mode, converter_mode_1;
    logic [MISC_W-1:0] misc;
    logic [CNT_W-1:0] timer_b_count, timer_c_count;
    logic [3:0] twb_low, twc_low;
    logic [OCT_W-1:0] octal;
    logic [PSS_W-1:0] serial_prescaler;
    logic [31:0] rdata;
    logic waitreq;
  } state_type;
  localparam state_type RESET_STATE = '{
    status: 1'b1, sp_low: SP_LOW_RESET, ctl: CTL_RESET,
    seq: SEQ_IDLE, ready: 1'b1, port_data: PORT_DATA_RESET,
    waitreq: 1'b1, pc: PC_RESET, default: '0};
  if (STACK_LEVELS != LEVELS)
    $error("cpu_regfile: stack depth is fixed by the pointer width");
  state_type s_q, s_d;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old_v,
    input logic [31:0] new_v, input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    return r;
  endfunction

  function automatic logic [31:0] read_mux(input state_type s,
                                           input logic [7:0] a);
    logic [31:0] r;
    r = '0;
    unique case (a)
      OFS_ACC: r[3:0] = s.accumulator;
      OFS_OPND: r[3:0] = s.operand_register;
      OFS_PAGE: r[1:0] = s.ram_page_index;
      OFS_IDX_HI: r[3:0] = s.ram_index_high;
      OFS_IDX_LO: r[3:0] = s.ram_index_low;
      OFS_SPARE_HI: r[3:0] = s.spare_index_high;
      OFS_SPARE_LO: r[3:0] = s.spare_index_low;
      OFS_FLAGS: r[1:0] = {s.status, s.carry_flag};
      OFS_PC: r[PC_W-1:0] = s.pc;
      OFS_SP: r[SP_W-1:0] = {SP_HIGH, s.sp_low};
      OFS_CTL: r[CTL_W-1:0] = s.ctl;
      OFS_PORT: r[14:0] = {s.port_mode_a, s.disc_dir, s.port_dir,
                           s.port_data};
      OFS_MODE: r[13:0] = {s.misc, s.converter_mode_1, s.serial_mode,
                           s.timer_b_mode_1};
      OFS_COUNT: r[26:0] = {s.octal, s.twc_low, s.twb_low,
                            s.timer_c_count, s.timer_b_count};
      OFS_PSS: r[PSS_W-1:0] = s.serial_prescaler;
      default: r = '0;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic take_op, bus_req;
  logic [31:0] wv;
  logic [SP_LOW_W-1:0] sp_pull;
  logic [ENTRY_W-1:0] top;
  always_comb
  begin
    s_d = s_q;
    take_op = op_valid_in && s_q.ready;
    bus_req = (avs_read_in || avs_write_in) && s_q.waitreq;
    wv = merge(read_mux(s_q, avs_address_in), avs_writedata_in,
               avs_byteenable_in);
    sp_pull = s_q.sp_low + SP_STEP;
    top = s_q.stack[sp_pull[SP_LOW_W-1:2]];
    if (clk_en_in)
    begin
      // Bus: answer one cycle after the request is seen
      s_d.waitreq = !bus_req;
      if (bus_req)
        s_d.rdata = read_mux(s_q, avs_address_in);
      if (bus_req && avs_write_in)
      begin
        unique case (avs_address_in)
          OFS_ACC: s_d.accumulator = wv[3:0];
          OFS_OPND: s_d.operand_register = wv[3:0];
          OFS_PAGE: s_d.ram_page_index = wv[1:0];
          OFS_IDX_HI: s_d.ram_index_high = wv[3:0];
          OFS_IDX_LO: s_d.ram_index_low = wv[3:0];
          OFS_SPARE_HI: s_d.spare_index_high = wv[3:0];
          OFS_SPARE_LO: s_d.spare_index_low = wv[3:0];
          OFS_FLAGS: s_d.carry_flag = wv[0];
          OFS_CTL:
          begin
            // Software may clear but never raise a request flag
            s_d.ctl = (wv[CTL_W-1:0] & ~CTL_IF_MASK)
                      | (wv[CTL_W-1:0] & s_q.ctl & CTL_IF_MASK);
            if (s_q.ctl[BIT_REINIT] && !wv[BIT_REINIT])
              s_d.sp_low = SP_LOW_RESET;
          end
          OFS_PORT:
            {s_d.port_mode_a, s_d.disc_dir, s_d.port_dir,
             s_d.port_data} = wv[14:0];
          OFS_MODE:
            {s_d.misc, s_d.converter_mode_1, s_d.serial_mode,
             s_d.timer_b_mode_1} = wv[13:0];
          OFS_COUNT:
            {s_d.octal, s_d.twc_low, s_d.twb_low, s_d.timer_c_count,
             s_d.timer_b_count} = wv[26:0];
          OFS_PSS: s_d.serial_prescaler = wv[PSS_W-1:0];
          default: s_d.rdata = s_d.rdata;
        endcase
      end
      // Interrupt entry sequence, cycle one was the accept cycle
      unique case (s_q.seq)
        SEQ_IDLE: s_d.seq = SEQ_IDLE;
        SEQ_PUSH:
        begin
          s_d.stack[s_q.sp_low[SP_LOW_W-1:2]] =
            {s_q.carry_flag, s_q.status, s_q.pc};
          s_d.sp_low = s_q.sp_low - SP_STEP;
          s_d.seq = SEQ_VECT;
        end
        SEQ_VECT:
        begin
          s_d.pc = s_q.vector;
          s_d.ctl[BIT_IE] = 1'b0;
          s_d.seq = SEQ_IDLE;
        end
        default: s_d.seq = SEQ_IDLE;
      endcase
      if (take_op)
      begin
        s_d.pc = s_q.pc + 14'h0001;
        unique case (op_code_in)
          OP_NOP: s_d.pc = s_d.pc;
          OP_LOAD:
            unique case (op_sel_in)
              3'h0: s_d.accumulator = op_data_in;
              3'h1: s_d.operand_register = op_data_in;
              3'h2: s_d.ram_page_index = op_data_in[1:0];
              3'h3: s_d.ram_index_high = op_data_in;
              3'h4: s_d.ram_index_low = op_data_in;
              3'h5: s_d.spare_index_high = op_data_in;
              3'h6: s_d.spare_index_low = op_data_in;
              default: s_d.pc = s_d.pc;
            endcase
          OP_ARITH:
          begin
            s_d.accumulator = op_data_in;
            s_d.carry_flag = op_carry_in;
            s_d.status = op_carry_in;
          end
          OP_STATUS: s_d.status = op_flag_in;
          OP_SET_C: s_d.carry_flag = 1'b1;
          OP_CLR_C: s_d.carry_flag = 1'b0;
          OP_ROTATE_LEFT_INSTR:
            {s_d.carry_flag, s_d.accumulator} =
              {s_q.accumulator, s_q.carry_flag};
          OP_ROTATE_RIGHT_INSTR:
            {s_d.accumulator, s_d.carry_flag} =
              {s_q.carry_flag, s_q.accumulator};
          OP_BRANCH:
          begin
            if (s_q.status)
              s_d.pc = op_target_in;
            s_d.status = 1'b1;
          end
          OP_CALL:
          begin
            if (s_q.status)
            begin
              s_d.stack[s_q.sp_low[SP_LOW_W-1:2]] =
                {s_q.carry_flag, s_q.status, s_d.pc};
              s_d.sp_low = s_q.sp_low - SP_STEP;
              s_d.pc = op_target_in;
            end
            s_d.status = 1'b1;
          end
          OP_RTN:
          begin
            s_d.pc = top[PC_W-1:0];
            s_d.sp_low = sp_pull;
          end
          OP_INTERRUPT_RETURN_INSTR:
          begin
            {s_d.carry_flag, s_d.status, s_d.pc} = top;
            s_d.sp_low = sp_pull;
            s_d.ctl[BIT_IE] = 1'b1;
          end
          OP_INT:
          begin
            // Hold the pc so the pushed address is the resume point
            s_d.pc = s_q.pc;
            s_d.vector = op_target_in;
            s_d.seq = SEQ_PUSH;
          end
          OP_BIT_SET:
            if (op_bit_in < 4'(CTL_W) && !CTL_IF_MASK[op_bit_in])
              s_d.ctl[op_bit_in] = 1'b1;
          OP_BIT_CLR:
            if (op_bit_in < 4'(CTL_W))
            begin
              s_d.ctl[op_bit_in] = 1'b0;
              if (op_bit_in == 4'(BIT_REINIT))
                s_d.sp_low = SP_LOW_RESET;
            end
          OP_BIT_TEST:
            if (op_bit_in < 4'(CTL_W))
              s_d.status = s_q.ctl[op_bit_in];
        endcase
      end
      // Hardware request beats a same-cycle software clear
      for (int i = 0; i < NIRQ; i++)
        if (irq_set_in[i])
          s_d.ctl[BIT_IF0 + i] = 1'b1;
      s_d.ready = (s_d.seq == SEQ_IDLE);
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      s_q <= RESET_STATE;
    else
      s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_readdata_out = s_q.rdata;
  assign avs_waitrequest_out = s_q.waitreq;
  assign op_ready_out = s_q.ready;
  assign accumulator_out = s_q.accumulator;
  assign operand_out = s_q.operand_register;
  assign ram_addr_out = {s_q.ram_page_index, s_q.ram_index_high,
                         s_q.ram_index_low};
  assign port_bit_sel_out = s_q.ram_index_low;
  assign carry_flag_out = s_q.carry_flag;
  assign branch_condition_flag_out = s_q.status;
  assign program_counter_out = s_q.pc;
  assign stack_pointer_out = {SP_HIGH, s_q.sp_low};
  assign ctl_bits_out = s_q.ctl;
  assign port_output_data_out = s_q.port_data;
  assign port_direction_0_out = s_q.port_dir;
  assign discrete_port_direction_0_out = s_q.disc_dir;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic acc_op;
  assign acc_op = op_valid_in && op_ready_out && clk_en_in;
  branch_status_a: assert property (@(posedge core_clk_in)
    acc_op && (op_code_in inside {OP_BRANCH, OP_CALL})
    |=> branch_condition_flag_out)
    else $error("status not forced after branch");
  call_push_a: assert property (@(posedge core_clk_in)
    acc_op && op_code_in == OP_CALL && branch_condition_flag_out
    |=> stack_pointer_out == $past(stack_pointer_out) - 10'h004)
    else $error("push did not step pointer down by four");
  sp_top_fixed_a: assert property (@(posedge core_clk_in)
    stack_pointer_out[9:6] == SP_HIGH)
    else $error("pointer top bits not all ones");
  reinit_sp_a: assert property (@(posedge core_clk_in)
    acc_op && op_code_in == OP_BIT_CLR && op_bit_in == 4'(BIT_REINIT)
    |=> stack_pointer_out == {SP_HIGH, SP_LOW_RESET})
    else $error("reinit clear did not reload pointer");
  int_entry_a: assert property (@(posedge core_clk_in)
    disable iff (rst_in || !clk_en_in)
    acc_op && op_code_in == OP_INT
    |=> !op_ready_out ##1 (stack_pointer_out ==
        $past(stack_pointer_out) - 10'h004)
        ##1 (program_counter_out == $past(op_target_in, 3)
        && !ctl_bits_out[BIT_IE] && op_ready_out))
    else $error("interrupt entry sequence wrong");
  rtn_carry_a: assert property (@(posedge core_clk_in)
    acc_op && op_code_in == OP_RTN |=> $stable(carry_flag_out))
    else $error("subroutine return touched carry");
  status_hold_a: assert property (@(posedge core_clk_in)
    acc_op && op_code_in inside {OP_NOP, OP_LOAD, OP_SET_C}
    |=> $stable(branch_condition_flag_out))
    else $error("status changed without cause");
  rotate_carry_a: assert property (@(posedge core_clk_in)
    acc_op && op_code_in == OP_ROTATE_LEFT_INSTR
    |=> carry_flag_out == $past(accumulator_out[3]))
    else $error("rotate left lost carry");
  reset_state_a: assert property (@(posedge core_clk_in)
    $past(rst_in) && !rst_in |-> program_counter_out == PC_RESET
    && branch_condition_flag_out && stack_pointer_out[5:0] == SP_LOW_RESET
    && ctl_bits_out == CTL_RESET && port_output_data_out == PORT_DATA_RESET)
    else $error("reset values wrong");
  bus_answer_a: assert property (@(posedge core_clk_in)
    disable iff (rst_in || !clk_en_in)
    (avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("bus answer not single cycle");
  port_select_a: assert property (acc_op && op_code_in == OP_LOAD
    && op_sel_in == 3'h4 |=> port_bit_sel_out == $past(op_data_in))
    else $error("port bit select differs from low index");
  int_entry_c: cover property (@(posedge core_clk_in)
    acc_op && op_code_in == OP_INT);
  interrupt_return_instr_c: cover property (@(posedge core_clk_in)
    acc_op && op_code_in == OP_INTERRUPT_RETURN_INSTR);
  irq_clear_race_c: cover property (@(posedge core_clk_in)
    irq_set_in[0] && avs_write_in && avs_address_in == OFS_CTL);

endmodule

// ---- tb/cpu_regfile_tb.sv ----
`timescale 1ns/1ps
module cpu_regfile_tb;
  import regfile_pkg::*;
  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic cen = 1'b1;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic ov = 1'b0;
  op_type oc = OP_NOP;
  logic [2:0] osel = 3'h0;
  logic [3:0] odat = 4'h0;
  logic [3:0] obit = 4'h0;
  logic ocy = 1'b0;
  logic ofl = 1'b0;
  logic [13:0] otgt = 14'h0;
  logic [4:0] irq = 5'h00;
  logic [31:0] rdat;
  logic [31:0] got;
  logic wreq;
  logic rdy;
  logic cy;
  logic st;
  logic [3:0] acc, opnd, psel, pdat, pdir, ddir;
  logic [9:0] ram, sp;
  logic [13:0] pc, pc0;
  logic [14:0] ctl;
  int n_fail = 0;
  int checked = 0;

  always #4 core_clk_in = ~core_clk_in;

  cpu_regfile u_cpu_regfile (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .clk_en_in(cen),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdat), .avs_byteenable_in(4'hf),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
    .op_valid_in(ov), .op_code_in(oc), .op_sel_in(osel),
    .op_data_in(odat), .op_carry_in(ocy), .op_flag_in(ofl),
    .op_target_in(otgt), .op_bit_in(obit), .op_ready_out(rdy),
    .irq_set_in(irq), .accumulator_out(acc), .operand_out(opnd),
    .ram_addr_out(ram), .port_bit_sel_out(psel), .carry_flag_out(cy),
    .branch_condition_flag_out(st), .program_counter_out(pc),
    .stack_pointer_out(sp), .ctl_bits_out(ctl),
    .port_output_data_out(pdat), .port_direction_0_out(pdir),
    .discrete_port_direction_0_out(ddir)
  );

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge core_clk_in);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    n = 0;
    do
    begin
      @(posedge core_clk_in);
      n++;
    end
    while (wreq !== 1'b0 && n < 50);
    got = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50)
      chk("bus answer", 32'h0, 32'h1);
  endtask

  // One argument serves as data, bit index and load target
  task automatic op(input op_type c, input logic [3:0] a,
                    input logic [13:0] t, input logic f);
    int n;
    @(posedge core_clk_in);
    oc <= c;
    odat <= a;
    obit <= a;
    osel <= a[2:0];
    otgt <= t;
    ocy <= f;
    ofl <= f;
    ov <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk_in);
      n++;
    end
    while (rdy !== 1'b1 && n < 50);
    ov <= 1'b0;
    #1;
    if (n >= 50)
      chk("op ready", 32'h0, 32'h1);
  endtask

  task automatic reset_chk;
    chk("pc", 32'(PC_RESET), 32'(pc));
    chk("status", 32'h1, 32'(st));
    chk("sp", 32'h3ff, 32'(sp));
    chk("ctl", 32'h07c0, 32'(ctl));
    chk("port", 32'h00f, 32'({ddir, pdir, pdat}));
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge core_clk_in);
    rst_in <= 1'b0;
    #1;
    reset_chk();
    bus(1'b0, OFS_PORT, 32'h0);
    chk("port reg", 32'h0000000f, got);
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b0, OFS_MODE + 8'(4 * i), 32'h0);
      chk("mode count prescaler", 32'h0, got);
    end
    $display("test reset done");
    for (int i = 0; i < 7; i++)
      bus(1'b1, 8'(4 * i), 32'(i + 9));
    for (int i = 0; i < 7; i++)
    begin
      bus(1'b0, 8'(4 * i), 32'h0);
      chk("work reg", (i == 2) ? 32'h3 : 32'(i + 9), got);
    end
    chk("accumulator", 32'h9, 32'(acc));
    chk("operand", 32'ha, 32'(opnd));
    chk("ram addr", 32'h3cd, 32'(ram));
    chk("port bit sel", 32'hd, 32'(psel));
    bus(1'b1, 8'h3c, 32'hffffffff);
    bus(1'b0, 8'h3c, 32'h0);
    chk("unmapped", 32'h0, got);
    $display("test registers done");
    op(OP_SET_C, 4'h0, 14'h0, 1'b0);
    chk("carry set", 32'h1, 32'(cy));
    op(OP_CLR_C, 4'h0, 14'h0, 1'b0);
    chk("carry clear", 32'h0, 32'(cy));
    op(OP_ROTATE_LEFT_INSTR, 4'h0, 14'h0, 1'b0);
    chk("rotate_left_instr", 32'h12, 32'({cy, acc}));
    op(OP_ROTATE_RIGHT_INSTR, 4'h0, 14'h0, 1'b0);
    chk("rotate_right_instr", 32'h09, 32'({cy, acc}));
    op(OP_ARITH, 4'h6, 14'h0, 1'b1);
    chk("overflow", 32'h3, 32'({cy, st}));
    op(OP_STATUS, 4'h0, 14'h0, 1'b0);
    op(OP_NOP, 4'h0, 14'h0, 1'b0);
    chk("status held", 32'h0, 32'(st));
    pc0 = pc;
    op(OP_BRANCH, 4'h0, 14'h123, 1'b0);
    chk("skip pc", 32'(pc0 + 14'h1), 32'(pc));
    chk("status forced", 32'h1, 32'(st));
    op(OP_BRANCH, 4'h0, 14'h123, 1'b0);
    chk("taken pc", 32'h123, 32'(pc));
    chk("status forced", 32'h1, 32'(st));
    $display("test flags done");
    op(OP_CLR_C, 4'h0, 14'h0, 1'b0);
    pc0 = pc;
    op(OP_CALL, 4'h0, 14'h200, 1'b0);
    chk("call pc", 32'h200, 32'(pc));
    chk("push sp", 32'h3fb, 32'(sp));
    op(OP_SET_C, 4'h0, 14'h0, 1'b0);
    op(OP_RTN, 4'h0, 14'h0, 1'b0);
    chk("return pc", 32'(pc0 + 14'h1), 32'(pc));
    chk("pull sp", 32'h3ff, 32'(sp));
    chk("carry kept", 32'h1, 32'(cy));
    bus(1'b1, OFS_CTL, 32'h07c1);
    op(OP_STATUS, 4'h0, 14'h0, 1'b0);
    pc0 = pc;
    op(OP_INT, 4'h0, 14'h00a, 1'b0);
    op(OP_NOP, 4'h0, 14'h0, 1'b0);
    chk("vector pc", 32'h00b, 32'(pc));
    chk("entry sp ie", 32'h7f6, 32'({sp, ctl[0]}));
    op(OP_CLR_C, 4'h0, 14'h0, 1'b0);
    op(OP_STATUS, 4'h0, 14'h0, 1'b1);
    op(OP_INTERRUPT_RETURN_INSTR, 4'h0, 14'h0, 1'b0);
    chk("interrupt_return_instr pc", 32'(pc0), 32'(pc));
    chk("interrupt_return_instr flags", 32'h2, 32'({cy, st}));
    chk("interrupt_return_instr sp ie", 32'h7ff, 32'({sp, ctl[0]}));
    $display("test stack done");
    op(OP_STATUS, 4'h0, 14'h0, 1'b1);
    op(OP_CALL, 4'h0, 14'h300, 1'b0);
    op(OP_BIT_SET, 4'he, 14'h0, 1'b0);
    chk("reinit bit", 32'h1, 32'(ctl[14]));
    op(OP_BIT_CLR, 4'he, 14'h0, 1'b0);
    chk("reinit sp", 32'h3ff, 32'(sp));
    @(posedge core_clk_in);
    irq <= 5'h01;
    @(posedge core_clk_in);
    irq <= 5'h00;
    #1;
    chk("request set", 32'h1, 32'(ctl[1]));
    op(OP_BIT_CLR, 4'h1, 14'h0, 1'b0);
    op(OP_BIT_SET, 4'h1, 14'h0, 1'b0);
    op(OP_BIT_CLR, 4'h6, 14'h0, 1'b0);
    chk("request mask", 32'h0, 32'({ctl[1], ctl[6]}));
    op(OP_BIT_TEST, 4'h6, 14'h0, 1'b0);
    chk("bit test clear", 32'h0, 32'(st));
    op(OP_BIT_TEST, 4'h7, 14'h0, 1'b0);
    chk("bit test set", 32'h1, 32'(st));
    op(OP_LOAD, 4'h4, 14'h0, 1'b0);
    chk("load index low", 32'h4, 32'(psel));
    @(posedge core_clk_in);
    cen <= 1'b0;
    pc0 = pc;
    op(OP_CLR_C, 4'h0, 14'h0, 1'b0);
    chk("frozen", 32'({1'b1, pc0}), 32'({cy, pc}));
    @(posedge core_clk_in);
    cen <= 1'b1;
    $display("test control bits done");
    @(posedge core_clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    rst_in <= 1'b0;
    #1;
    reset_chk();
    $display("test second reset done");
    give_verdict();
  end

  // A hang counts as a mismatch
  initial
  begin
    #40000;
    n_fail++;
    give_verdict();
  end
endmodule
